// File: mcid_pkg.sv
`default_nettype none
package mcid_pkg;
    localparam int          NUM_CORES      = 4;
    localparam int          NUM_SPI        = 224;
    localparam int          NUM_IRQ        = 256;
    localparam int          PRIO_W         = 5;
    localparam logic [3:0]  CLK_RATIO      = 4'h2;
    // Page offsets inside the 32KB controller window
    localparam logic [14:0] RSV_BASE       = 15'h0000;
    localparam logic [14:0] DIST_BASE      = 15'h1000;
    localparam logic [14:0] CPUIF_BASE     = 15'h2000;
    localparam logic [14:0] VCTL_ALIAS     = 15'h4000;
    localparam logic [14:0] VCTL_BANKED    = 15'h5000;
    localparam logic [14:0] VCPU_BASE      = 15'h6000;
    localparam logic [14:0] PAGE4K_MASK    = 15'h7000;
    localparam logic [14:0] PAGE8K_MASK    = 15'h6000;
    // Distributor registers
    localparam logic [11:0] D_CTRL         = 12'h000;
    localparam logic [11:0] D_SOFT_TRIG    = 12'hF00;
    localparam logic [11:0] D_CFG_BASE     = 12'hFC0;
    localparam logic [11:0] D_L2CTRL       = 12'hFC4;
    localparam logic [11:0] D_PRIO         = 12'h400;
    localparam logic [11:0] D_PRIO_END     = 12'h4FC;
    localparam logic [11:0] D_PEND         = 12'h200;
    localparam logic [11:0] D_PEND_END     = 12'h21C;
    localparam logic [11:0] D_EN           = 12'h100;
    localparam logic [11:0] D_EN_END       = 12'h11C;
    // CPU interface registers
    localparam logic [11:0] C_CTRL         = 12'h000;
    localparam logic [11:0] C_ACK          = 12'h00C;
    localparam logic [11:0] C_VCTL         = 12'h000;
    localparam int          L2_GIC_BIT     = 23;
    localparam logic [7:0]  ID_FIQ         = 8'h1C;
    localparam logic [7:0]  ID_STIMER      = 8'h1D;
    localparam logic [7:0]  ID_NTIMER      = 8'h1E;
    localparam logic [7:0]  ID_IRQ         = 8'h1F;
    localparam logic [7:0]  ID_VTIMER      = 8'h1B;
    localparam logic [7:0]  ID_HTIMER      = 8'h1A;
    localparam logic [7:0]  ID_MAINT       = 8'h19;
    localparam logic [7:0]  ID_SPURIOUS    = 8'hFF;
    typedef enum logic [2:0] {
        MCID_IDLE = 3'b001,
        MCID_DO   = 3'b010,
        MCID_ACK  = 3'b100
    } mcid_bus_t;
endpackage
`default_nettype wire

// File: mcid_top.sv
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module mcid_top #(
    parameter int NUM_SPI_CFG = 224,         // Implemented shared lines
    parameter bit GIC_PRESENT = 1'b1         // Controller included
) (
    input  wire logic         clk_i,                     // Core clock
    input  wire logic         rst_i,                     // Sync reset
    input  wire logic         slow_clock_enable_i,       // Slow enable
    input  wire logic [39:15] controller_base_address_i, // Base strap
    input  wire logic [39:0]  wb_adr_i,                  // Byte address
    input  wire logic [31:0]  wb_dat_i,                  // Write data
    input  wire logic [3:0]   wb_sel_i,                  // Byte lanes
    input  wire logic         wb_we_i,                   // Write
    input  wire logic         wb_cyc_i,                  // Cycle
    input  wire logic         wb_stb_i,                  // Strobe
    input  wire logic [1:0]   req_core_i,                // Requesting core
    input  wire logic         req_multi_i,               // Multi/double op
    input  wire logic         req_acp_i,                 // Coherency port
    output logic [31:0]       wb_dat_o,                  // Read data
    output logic              wb_ack_o,                  // Acknowledge
    output logic              wb_err_o,                  // Data abort
    output logic              ext_mem_fwd_o,             // Sent to memory
    output logic              bus_error_irq_n_o,         // Bus error
    input  wire logic [3:0]   fast_interrupt_in_n_i,     // Per core
    input  wire logic [3:0]   normal_interrupt_in_n_i,   // Per core
    input  wire logic [3:0]   sec_timer_n_i,             // Per core
    input  wire logic [3:0]   nsec_timer_n_i,            // Per core
    input  wire logic [3:0]   virt_timer_n_i,            // Per core
    input  wire logic [3:0]   hyp_timer_n_i,             // Per core
    input  wire logic [3:0]   maint_irq_i,               // Per core
    input  wire logic [223:0] shared_interrupt_lines_i,  // Shared lines
    output logic [3:0]        core_irq_n_o,              // To cores
    output logic [3:0]        core_fiq_n_o               // To cores
);
    localparam int NC = mcid_pkg::NUM_CORES;
    localparam int NI = mcid_pkg::NUM_IRQ;
    localparam int PW = mcid_pkg::PRIO_W;

    logic [39:15]  cfg_base [NC];            // Per-core base copy
    logic          dist_en;
    logic [NC-1:0] cpu_en;
    logic [NI-1:0] enable;
    logic [NI-1:0] edge_cfg;                 // Shared: 1 edge, 0 level
    logic [NI-1:0] spi_pend;
    logic [15:0]   sgi_pend [NC];
    logic [PW-1:0] prio [NI];
    logic [255:0]  spi_prev;
    logic [31:0]   vctl_reg [NC];
    logic [31:0]   rdata;
    logic          hit_ok;
    logic          bad;

    ////////////////////////////////////////////////////////////////////////////
    // Base address capture while reset is held
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int c = 0; c < NC; c++) begin
                cfg_base[c] <= controller_base_address_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Address decode
    logic [14:0] off;
    logic        in_win;
    logic        pg_dist;
    logic        pg_cpu;
    logic        pg_alias;
    logic        pg_bank;
    logic        pg_vcpu;
    logic        size_ok;
    logic [1:0]  vcore;
    assign off      = wb_adr_i[14:0];
    assign in_win   = (wb_adr_i[39:15] == cfg_base[req_core_i]);
    assign pg_dist  = (off & mcid_pkg::PAGE4K_MASK) == mcid_pkg::DIST_BASE;
    assign pg_cpu   = (off & mcid_pkg::PAGE8K_MASK) == mcid_pkg::CPUIF_BASE;
    assign pg_alias = (off & mcid_pkg::PAGE4K_MASK) == mcid_pkg::VCTL_ALIAS;
    assign pg_bank  = (off & mcid_pkg::PAGE4K_MASK) == mcid_pkg::VCTL_BANKED;
    assign pg_vcpu  = (off & mcid_pkg::PAGE8K_MASK) == mcid_pkg::VCPU_BASE;
    // Alias uses requester, banked page uses bits 10:9
    assign vcore    = pg_bank ? off[10:9] : req_core_i;
    // Word access anywhere; byte access only in the priority table
    assign size_ok  = (wb_sel_i == 4'hF) ||
                      (pg_dist && off[11:8] == mcid_pkg::D_PRIO[11:8] &&
                       $countones(wb_sel_i) == 1);
    assign hit_ok   = GIC_PRESENT && (pg_dist || pg_cpu || pg_alias ||
                      pg_bank || pg_vcpu);
    assign bad      = !hit_ok || !size_ok || req_multi_i;

    ////////////////////////////////////////////////////////////////////////////
    // Read mux
    always_comb begin
        rdata = 32'h0000_0000;
        if (pg_dist) begin
            if (off[11:0] == mcid_pkg::D_CTRL) begin
                rdata = {31'h0, dist_en};
            end else if (off[11:0] == mcid_pkg::D_CFG_BASE) begin
                rdata = {cfg_base[req_core_i][31:15], 15'h0000};
            end else if (off[11:0] == mcid_pkg::D_L2CTRL) begin
                rdata[mcid_pkg::L2_GIC_BIT] = GIC_PRESENT;
            end else if (off[11:8] == mcid_pkg::D_PRIO[11:8]) begin
                for (int b = 0; b < 4; b++) begin
                    rdata[b*8 +: PW] = prio[{off[7:2], 2'(b)}];
                end
            end else if (off[11:5] == mcid_pkg::D_PEND[11:5]) begin
                rdata = spi_pend[off[4:2]*32 +: 32];
            end else if (off[11:5] == mcid_pkg::D_EN[11:5]) begin
                rdata = enable[off[4:2]*32 +: 32];
            end
        end else if (pg_cpu) begin
            if (off[11:0] == mcid_pkg::C_CTRL) begin
                rdata = {31'h0, cpu_en[req_core_i]};
            end else if (off[11:0] == mcid_pkg::C_ACK) begin
                rdata = {24'h0, best_id(req_core_i)};
            end
        end else if (pg_alias || pg_bank) begin
            rdata = vctl_reg[vcore];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Wishbone slave: one access per slow tick
    logic take;
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o &&
                  slow_clock_enable_i;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o          <= 1'b0;
            wb_err_o          <= 1'b0;
            wb_dat_o          <= 32'h0000_0000;
            ext_mem_fwd_o     <= 1'b0;
            bus_error_irq_n_o <= 1'b1;
        end else begin
            wb_ack_o      <= 1'b0;
            wb_err_o      <= 1'b0;
            ext_mem_fwd_o <= 1'b0;
            if (take) begin
                if (req_acp_i || !in_win) begin
                    wb_ack_o      <= 1'b1;
                    ext_mem_fwd_o <= 1'b1;
                end else if (bad && !wb_we_i) begin
                    wb_err_o <= 1'b1;
                end else if (bad) begin
                    wb_ack_o          <= 1'b1;
                    bus_error_irq_n_o <= 1'b0;
                end else begin
                    wb_ack_o <= 1'b1;
                    wb_dat_o <= wb_we_i ? 32'h0000_0000 : rdata;
                end
            end
            // Error line clears when software writes the distributor control word with bit 31 set
            if (take && wb_we_i && !bad && pg_dist &&
                off[11:0] == mcid_pkg::D_CTRL && wb_dat_i[31]) begin
                bus_error_irq_n_o <= 1'b1;
            end
        end
    end

    logic wr;
    assign wr = take && wb_we_i && !bad && !req_acp_i && in_win;

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dist_en  <= 1'b0;
            cpu_en   <= '0;
            enable   <= {{(NI-16){1'b0}}, 16'hFFFF};
            edge_cfg <= '0;
            for (int i = 0; i < NI; i++) begin
                prio[i] <= '0;
            end
            for (int c = 0; c < NC; c++) begin
                vctl_reg[c] <= 32'h0000_0000;
            end
        end else if (wr) begin
            if (pg_dist && off[11:0] == mcid_pkg::D_CTRL) begin
                dist_en <= wb_dat_i[0];
            end else if (pg_dist && off[11:8] == mcid_pkg::D_PRIO[11:8]) begin
                for (int b = 0; b < 4; b++) begin
                    if (wb_sel_i[b]) begin
                        prio[{off[7:2], 2'(b)}] <= wb_dat_i[b*8 +: PW];
                    end
                end
            end else if (pg_dist && off[11:5] == mcid_pkg::D_EN[11:5]) begin
                enable[off[4:2]*32 +: 32] <= wb_dat_i;
                edge_cfg[off[4:2]*32 +: 32] <= wb_dat_i;
            end else if (pg_cpu && off[11:0] == mcid_pkg::C_CTRL) begin
                cpu_en[req_core_i] <= wb_dat_i[0];
            end else if (pg_alias || pg_bank) begin
                vctl_reg[vcore] <= wb_dat_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pending state; set beats clear
    logic [NI-1:0] spi_raw;
    always_comb begin
        spi_raw = '0;
        for (int i = 0; i < NUM_SPI_CFG; i++) begin
            spi_raw[32+i] = shared_interrupt_lines_i[i];
        end
    end
    logic [1:0] own;
    assign own = req_core_i;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            spi_pend <= '0;
            spi_prev <= '0;
            for (int c = 0; c < NC; c++) begin
                sgi_pend[c] <= 16'h0000;
            end
        end else if (slow_clock_enable_i) begin
            spi_prev <= spi_raw;
            for (int i = 32; i < NI; i++) begin
                if (spi_raw[i] && !spi_prev[i]) begin
                    spi_pend[i] <= 1'b1;
                end else if (wr && pg_dist &&
                             off[11:5] == mcid_pkg::D_PEND[11:5] &&
                             off[4:2] == i[7:5] && wb_dat_i[i%32]) begin
                    spi_pend[i] <= 1'b0;
                end
            end
            for (int c = 0; c < NC; c++) begin
                if (wr && pg_dist && off[11:0] == mcid_pkg::D_SOFT_TRIG &&
                    wb_dat_i[16+c]) begin
                    sgi_pend[c][wb_dat_i[3:0]] <= 1'b1;
                end else if (wr && pg_cpu &&
                             off[11:0] == mcid_pkg::C_ACK &&
                             c == int'(own)) begin
                    sgi_pend[c] <= 16'h0000;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-core request vector and arbitration
    function automatic logic [NI-1:0] req_vec(input int c);
        logic [NI-1:0] v;
        v = '0;
        v[15:0] = sgi_pend[c];
        v[mcid_pkg::ID_MAINT]  = maint_irq_i[c];
        v[mcid_pkg::ID_HTIMER] = !hyp_timer_n_i[c];
        v[mcid_pkg::ID_VTIMER] = !virt_timer_n_i[c];
        v[mcid_pkg::ID_FIQ]    = !fast_interrupt_in_n_i[c];
        v[mcid_pkg::ID_STIMER] = !sec_timer_n_i[c];
        v[mcid_pkg::ID_NTIMER] = !nsec_timer_n_i[c];
        v[mcid_pkg::ID_IRQ]    = !normal_interrupt_in_n_i[c];
        for (int i = 32; i < NI; i++) begin
            v[i] = edge_cfg[i] ? spi_pend[i] : spi_raw[i];
        end
        req_vec = v & enable;
    endfunction

    function automatic logic [7:0] best_id(input logic [1:0] c);
        logic [NI-1:0] v;
        logic [PW:0]   bp;
        v = req_vec(int'(c));
        bp = {1'b1, {PW{1'b1}}};
        best_id = mcid_pkg::ID_SPURIOUS;
        for (int i = 0; i < NI; i++) begin
            if (v[i] && {1'b0, prio[i]} < bp) begin
                bp = {1'b0, prio[i]};
                best_id = 8'(i);
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Core outputs: legacy bypass until interface is enabled
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            core_irq_n_o <= 4'hF;
            core_fiq_n_o <= 4'hF;
        end else if (slow_clock_enable_i) begin
            for (int c = 0; c < NC; c++) begin
                if (!cpu_en[c]) begin
                    core_fiq_n_o[c] <= fast_interrupt_in_n_i[c];
                    core_irq_n_o[c] <= normal_interrupt_in_n_i[c];
                end else begin
                    core_fiq_n_o[c] <= 1'b1;
                    core_irq_n_o[c] <= !(dist_en &&
                        best_id(2'(c)) != mcid_pkg::ID_SPURIOUS);
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_reserved_abort;
        @(posedge clk_i) disable iff (rst_i)
        (take && !wb_we_i && in_win && !req_acp_i &&
         (off & mcid_pkg::PAGE4K_MASK) == mcid_pkg::RSV_BASE) |=> wb_err_o;
    endproperty
    a_reserved_abort: assert property (p_reserved_abort)
        else $error("reserved read did not abort");

    property p_multi_store;
        @(posedge clk_i) disable iff (rst_i)
        (take && wb_we_i && req_multi_i && in_win && !req_acp_i)
        |=> !bus_error_irq_n_o && wb_ack_o;
    endproperty
    a_multi_store: assert property (p_multi_store)
        else $error("multi store did not raise bus error");

    property p_half_read;
        @(posedge clk_i) disable iff (rst_i)
        (take && !wb_we_i && in_win && !req_acp_i && wb_sel_i == 4'h3)
        |=> wb_err_o;
    endproperty
    a_half_read: assert property (p_half_read)
        else $error("halfword read did not abort");

    property p_acp;
        @(posedge clk_i) disable iff (rst_i)
        (take && req_acp_i) |=> ext_mem_fwd_o && !wb_err_o;
    endproperty
    a_acp: assert property (p_acp)
        else $error("coherency port access not forwarded");

    property p_slow;
        @(posedge clk_i) disable iff (rst_i)
        !slow_clock_enable_i |=> $stable(core_irq_n_o) &&
                                 $stable(core_fiq_n_o);
    endproperty
    a_slow: assert property (p_slow)
        else $error("core outputs moved without enable");

    property p_legacy;
        @(posedge clk_i) disable iff (rst_i)
        (slow_clock_enable_i && !cpu_en[0])
        |=> core_fiq_n_o[0] == $past(fast_interrupt_in_n_i[0]);
    endproperty
    a_legacy: assert property (p_legacy)
        else $error("legacy fast bypass broken");

    property p_base;
        @(posedge clk_i) disable iff (rst_i)
        take && !wb_we_i && !bad && in_win && !req_acp_i && pg_dist &&
        off[11:0] == mcid_pkg::D_CFG_BASE
        |=> wb_dat_o[31:15] == $past(cfg_base[req_core_i][31:15]);
    endproperty
    a_base: assert property (p_base)
        else $error("base register readback wrong");

    property p_cpu_page;
        @(posedge clk_i) disable iff (rst_i)
        (GIC_PRESENT && take && !wb_we_i && in_win && !req_acp_i &&
         !req_multi_i && wb_sel_i == 4'hF && off[14:12] == 3'h3)
        |=> wb_ack_o && !wb_err_o;
    endproperty
    a_cpu_page: assert property (p_cpu_page)
        else $error("upper half of cpu page not decoded");
endmodule
`default_nettype wire

// File: mcid_cores.sv
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Far side: core 0 sources driven on request, other cores held idle
module mcid_cores (
    input  wire logic [7:0]   req_i,    // Source on, high = asserted
    output logic [3:0]        fiq_n_o,  // Fast lines
    output logic [3:0]        irq_n_o,  // Normal lines
    output logic [3:0]        stim_n_o, // Secure timer
    output logic [3:0]        ntim_n_o, // Non-secure timer
    output logic [3:0]        vtim_n_o, // Virtual timer
    output logic [3:0]        htim_n_o, // Hypervisor timer
    output logic [3:0]        maint_o,  // Maintenance
    output logic [223:0]      spi_o,    // Shared lines
    output logic [3:0]        virtual_interrupt_in_n_o,      // Tied high
    output logic [3:0]        virtual_fast_interrupt_in_n_o  // Tied high
);
    // Internal controller in use, so the virtual inputs stay idle
    assign virtual_interrupt_in_n_o      = 4'hF;
    assign virtual_fast_interrupt_in_n_o = 4'hF;
    assign fiq_n_o  = {3'h7, ~req_i[0]};
    assign stim_n_o = {3'h7, ~req_i[1]};
    assign ntim_n_o = {3'h7, ~req_i[2]};
    assign irq_n_o  = {3'h7, ~req_i[3]};
    assign vtim_n_o = {3'h7, ~req_i[4]};
    assign htim_n_o = {3'h7, ~req_i[5]};
    assign maint_o  = {3'h0, req_i[6]};
    assign spi_o    = {223'h0, req_i[7]};
endmodule
`default_nettype wire

// File: multicore_interrupt_distributor_tb.sv
`timescale 1ns/100ps
`default_nettype none
module multicore_interrupt_distributor_tb;
    typedef struct packed {
        logic        we;
        logic [14:0] off;
        logic [3:0]  sel;
        logic [1:0]  md;
        logic [31:0] d;
        logic        err;
        logic        irq;
        logic [31:0] m;
    } mcid_row_t;
    localparam logic [24:0] BASE = 25'h0000123; // Constant strap
    logic         clk_i, rst_i, en, hold, cyc, we, multi, cport;
    logic         ack, err, fwd, berr_n, g_err, g_fwd;
    logic [39:0]  adr;
    logic [31:0]  wd, dato, rd;
    logic [3:0]   sel, fq, nq, st, nt, vt, ht, mt, irq_n, fiq_n, vi_n, vf_n;
    logic [1:0]   cr;
    logic [7:0]   req;
    logic [223:0] spi;
    int           bad_count, num_checks, lat;
    mcid_row_t    rows [17];
    logic [7:0]   ids [8];

    mcid_cores far (.req_i(req), .fiq_n_o(fq), .irq_n_o(nq), .stim_n_o(st),
        .ntim_n_o(nt), .vtim_n_o(vt), .htim_n_o(ht), .maint_o(mt),
        .spi_o(spi), .virtual_interrupt_in_n_o(vi_n),
        .virtual_fast_interrupt_in_n_o(vf_n));
    mcid_top dut (.clk_i, .rst_i, .slow_clock_enable_i(en),
        .controller_base_address_i(BASE), .wb_adr_i(adr), .wb_dat_i(wd),
        .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .req_core_i(cr), .req_multi_i(multi), .req_acp_i(cport),
        .wb_dat_o(dato), .wb_ack_o(ack), .wb_err_o(err),
        .ext_mem_fwd_o(fwd), .bus_error_irq_n_o(berr_n),
        .fast_interrupt_in_n_i(fq), .normal_interrupt_in_n_i(nq),
        .sec_timer_n_i(st), .nsec_timer_n_i(nt), .virt_timer_n_i(vt),
        .hyp_timer_n_i(ht), .maint_irq_i(mt),
        .shared_interrupt_lines_i(spi), .core_irq_n_o(irq_n),
        .core_fiq_n_o(fiq_n));

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    // Two-to-one ratio; hold parks the enable to prove stalling
    always @(posedge clk_i) en <= (hold || rst_i) ? 1'b0 : ~en;
    ////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        num_checks++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            bad_count++;
        end
    endtask
    task automatic bus(input logic [14:0] o, input logic w,
                       input logic [3:0] s, input logic [1:0] md,
                       input logic [31:0] d);
        @(posedge clk_i);
        adr   <= {BASE, o};
        we    <= w;
        sel   <= s;
        wd    <= d;
        multi <= md[1];
        cport <= md[0];
        cyc   <= 1'b1;
        lat = 0;
        do begin
            @(posedge clk_i);
            lat++;
        end while (ack !== 1'b1 && err !== 1'b1 && lat < 60);
        chk("bus_wait", 32'h1, 32'(lat < 60));
        if (lat >= 60) end_sim();
        g_err = err;
        g_fwd = fwd;
        rd    = dato;
        cyc   <= 1'b0;
    endtask
    // k: 0 fast line, 1 normal line, 2 either
    task automatic wait_low(input int k);
        int n;
        n = 0;
        while (n < 40 && (k == 0 ? fiq_n[0] : k == 1 ? irq_n[0]
               : irq_n[0] & fiq_n[0]) !== 1'b0) begin
            @(posedge clk_i);
            n++;
        end
        chk("line_low", 32'h1, 32'(n < 40));
        if (n >= 40) end_sim();
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_i = 1'b1;
        hold = 1'b0;
        cr = 2'h0;
        cyc = 1'b0;
        we = 1'b0;
        multi = 1'b0;
        cport = 1'b0;
        sel = 4'h0;
        adr = 40'h0;
        wd = 32'h0;
        req = 8'h00;
        bad_count = 0;
        num_checks = 0;
        ids = '{mcid_pkg::ID_FIQ, mcid_pkg::ID_STIMER, mcid_pkg::ID_NTIMER,
                mcid_pkg::ID_IRQ, mcid_pkg::ID_VTIMER, mcid_pkg::ID_HTIMER,
                mcid_pkg::ID_MAINT, 8'h20};
        rows = '{
        '{1'b0, 15'h1FC0, 4'hF, 2'h0, 32'h00918000, 1'b0, 1'b0, 32'hFFFF8000},
        '{1'b0, 15'h1FC4, 4'hF, 2'h0, 32'h00800000, 1'b0, 1'b0, 32'h00800000},
        '{1'b0, 15'h0010, 4'hF, 2'h0, 32'h0, 1'b1, 1'b0, 32'h0},
        '{1'b1, 15'h0010, 4'hF, 2'h0, 32'h0, 1'b0, 1'b1, 32'h0},
        '{1'b0, 15'h1000, 4'h3, 2'h0, 32'h0, 1'b1, 1'b0, 32'h0},
        '{1'b1, 15'h1000, 4'hC, 2'h0, 32'h0, 1'b0, 1'b1, 32'h0},
        '{1'b0, 15'h1000, 4'hF, 2'h2, 32'h0, 1'b1, 1'b0, 32'h0},
        '{1'b1, 15'h1000, 4'hF, 2'h2, 32'h0, 1'b0, 1'b1, 32'h0},
        '{1'b0, 15'h1000, 4'hF, 2'h1, 32'h0, 1'b0, 1'b0, 32'h0},
        '{1'b1, 15'h1400, 4'h1, 2'h0, 32'hFF, 1'b0, 1'b0, 32'h0},
        '{1'b1, 15'h1000, 4'h1, 2'h0, 32'h0, 1'b0, 1'b1, 32'h0},
        '{1'b0, 15'h2000, 4'hF, 2'h0, 32'h0, 1'b0, 1'b0, 32'hFFFFFFFF},
        '{1'b0, 15'h4000, 4'hF, 2'h0, 32'h0, 1'b0, 1'b0, 32'hFFFFFFFF},
        '{1'b0, 15'h5600, 4'hF, 2'h0, 32'h0, 1'b0, 1'b0, 32'hFFFFFFFF},
        '{1'b0, 15'h6000, 4'hF, 2'h0, 32'h0, 1'b0, 1'b0, 32'hFFFFFFFF},
        '{1'b0, 15'h3FFC, 4'hF, 2'h0, 32'h0, 1'b0, 1'b0, 32'hFFFFFFFF},
        '{1'b0, 15'h0FFC, 4'hF, 2'h0, 32'h0, 1'b1, 1'b0, 32'h0}};
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk("rst_berr", 32'h1, berr_n);
        chk("rst_irq", 32'hF, irq_n);
        chk("virt_tie", 32'hFF, {vi_n, vf_n});
        foreach (rows[i]) begin
            bus(rows[i].off, rows[i].we, rows[i].sel, rows[i].md, rows[i].d);
            chk("err", rows[i].err, g_err);
            chk("fwd", rows[i].md[0], g_fwd);
            if (!rows[i].we && !rows[i].err)
                chk("rdat", rows[i].d & rows[i].m, rd & rows[i].m);
            repeat (2) @(posedge clk_i);
            chk("berr", !rows[i].irq, berr_n);
            if (rows[i].irq)
                bus(15'h1000, 1'b1, 4'hF, 2'h0, 32'h80000000);
        end
        cr <= 2'h2;
        bus(15'h4000, 1'b1, 4'hF, 2'h0, 32'h0000ABCD);
        cr <= 2'h0;
        bus(15'h5400, 1'b0, 4'hF, 2'h0, 32'h0);
        chk("vctl_bank", 32'h0000ABCD, rd);
        bus(15'h4000, 1'b0, 4'hF, 2'h0, 32'h0);
        chk("vctl_own", 32'h0, rd);
        $display("table done");
        hold <= 1'b1;
        fork
            begin
                repeat (8) @(posedge clk_i);
                hold <= 1'b0;
            end
        join_none
        bus(15'h1FC4, 1'b0, 4'hF, 2'h0, 32'h0);
        chk("stall_lat", 32'h1, 32'(lat > 6));
        chk("l2_bit", 32'h00800000, rd & 32'h00800000);
        $display("stall done");
        req <= 8'h01;
        wait_low(0);
        req <= 8'h08;
        wait_low(1);
        req <= 8'h00;
        repeat (6) @(posedge clk_i);
        $display("legacy done");
        bus(15'h2000, 1'b1, 4'hF, 2'h0, 32'h1);
        bus(15'h1000, 1'b1, 4'hF, 2'h0, 32'h1);
        bus(15'h1100, 1'b1, 4'hF, 2'h0, 32'hFE00FFFF);
        bus(15'h1104, 1'b1, 4'hF, 2'h0, 32'h1);
        bus(15'h1F00, 1'b1, 4'hF, 2'h0, 32'h00010005);
        wait_low(2);
        bus(15'h200C, 1'b0, 4'hF, 2'h0, 32'h0);
        chk("soft_id", 32'h5, rd & 32'hFF);
        bus(15'h200C, 1'b1, 4'hF, 2'h0, 32'h0);
        bus(15'h200C, 1'b0, 4'hF, 2'h0, 32'h0);
        chk("soft_clr", 32'hFF, rd & 32'hFF);
        $display("soft done");
        for (int k = 0; k < 8; k++) begin
            req <= 8'h01 << k;
            wait_low(2);
            bus(15'h200C, 1'b0, 4'hF, 2'h0, 32'h0);
            chk("src_id", ids[k], rd & 32'hFF);
            req <= 8'h00;
            repeat (6) @(posedge clk_i);
        end
        $display("sources done");
        rst_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk("rst2_irq", 32'hF, irq_n);
        bus(15'h1100, 1'b0, 4'hF, 2'h0, 32'h0);
        chk("rst2_en", 32'h0000FFFF, rd);
        $display("reset done");
        end_sim();
    end
endmodule
`default_nettype wire
